/* hw/twm_slave.sv */
// two-wire memory slave port with page write and nv write timer
// How it works
// RULE1: sda fall with scl high starts
// RULE2: sda rise with scl high stops
// RULE3: sda changes while scl high are conditions
// RULE4: slave acks each byte on ninth clock
// RULE5: idle standby after reset, stop, write
// RULE6: master clocks nine times to recover bus; the code stops early once sda reads high with scl high
// RULE7: address word is 1010, select, direction
// RULE8: direction one reads, zero writes
// RULE9: ack only on select match, else standby
// RULE10: write sends memory address then data
// RULE11: nv write after stop ignores bus
// RULE12: page write up to eight bytes
// RULE13: commit only when stop ends write
// RULE14: no address ack during nv write
// RULE15: address counter increments and wraps
// RULE16: current-address read sends counter byte
// RULE17: random read via dummy write, restart
// RULE18: sequential read on master ack, wraps
// RULE19: enable bit picks pin or stored select
// RULE20: write protect high blocks bus writes
// RULE21: nv write time is a parameter
`timescale 1ns/100ps
module twm_slave #(
  parameter int NV_CYC = twm_pkg::NV_WRITE_CYC  // [RULE21]
) (
  input  wire logic       I_MCLK,
  input  wire logic       I_RST_B,
  input  wire logic       I_CE,
  input  wire logic [2:0] I_SEL_PINS,
  input  wire logic       I_WP,
  output logic            O_STANDBY,
  output logic            O_NV_BUSY,
  twm_bus_if.slave        bus
);
  typedef enum {S_IDLE, S_ADDR, S_AACK, S_MADR, S_MACK, S_WDAT, S_WACK,
                S_RDAT, S_RACK} twm_st_type;
  typedef struct packed {
    logic [2:0]  scl_s;
    logic [2:0]  sda_s;
    twm_st_type  st;
    logic [3:0]  bitc;
    logic [7:0]  sh;
    logic [7:0]  ptr;
    logic [7:0]  pg_base;
    logic [3:0]  pg_cnt;
    logic        wr_pend;
    logic [31:0] nv_cnt;
    logic        sda_oe;
    logic        addr_ok;
    logic        rd;
  } twm_s_type;
  twm_s_type q, d;
  logic [7:0] mem [0:255];
  logic [7:0] pg_buf [0:7];
  logic [7:0] sel_reg;
  logic       scl_h, sda_h, scl_rise, scl_fall, start_c, stop_c;
  logic       commit;
  logic       pg_we;
  logic [2:0] dev_sel;
  // high level needs both 2nd/3rd stages high: only stages 1,2 read
  assign scl_h    = q.scl_s[1] & q.scl_s[2];
  assign sda_h    = q.sda_s[1] & q.sda_s[2];
  assign scl_rise = q.scl_s[1] & ~q.scl_s[2];
  assign scl_fall = ~q.scl_s[1] & q.scl_s[2];
  assign start_c  = scl_h & ~q.sda_s[1] & q.sda_s[2];  // [RULE1] [RULE3]
  assign stop_c   = scl_h & q.sda_s[1] & ~q.sda_s[2];  // [RULE2] [RULE3]
  assign dev_sel  = sel_reg[twm_pkg::ENB_BIT] ? I_SEL_PINS  // [RULE19]
                    : sel_reg[twm_pkg::SEL_LSB +: 3];
  always_comb begin
    d        = q;
    commit   = 1'b0;
    pg_we    = 1'b0;
    d.scl_s  = {q.scl_s[1:0], bus.scl};
    d.sda_s  = {q.sda_s[1:0], bus.sda};
    if (q.nv_cnt != 32'h0000_0000) begin
      d.nv_cnt = q.nv_cnt - 32'h0000_0001;  // [RULE11]
      d.st     = S_IDLE;
      d.sda_oe = 1'b0;
    end else if (start_c) begin
      d.wr_pend = 1'b0;  // [RULE13]
      d.pg_cnt  = 4'h0;
      d.st     = S_ADDR;
      d.bitc   = 4'h0;
      d.sda_oe = 1'b0;
    end else if (stop_c) begin
      d.st     = S_IDLE;  // [RULE2] [RULE5]
      d.sda_oe = 1'b0;
      if (q.wr_pend && q.pg_cnt != 4'h0) begin
        commit   = 1'b1;  // [RULE13]
        d.nv_cnt = NV_CYC;
      end
      d.wr_pend = 1'b0;
      d.pg_cnt  = 4'h0;
    end else if (scl_rise) begin
      unique case (q.st)
        S_ADDR, S_MADR, S_WDAT: begin
          d.sh   = {q.sh[6:0], sda_h};  // [RULE7]
          d.bitc = q.bitc + 4'h1;
        end
        S_RACK: begin
          if (sda_h) d.st = S_IDLE;  // [RULE16] [RULE18]
          else d.st = S_AACK;  // next byte loads on the ninth fall
          d.bitc = 4'h0;
        end
        default: ;
      endcase
    end else if (scl_fall) begin
      unique case (q.st)
        S_ADDR: if (q.bitc == 4'h8) begin
          if (q.sh[7:4] == twm_pkg::DEV_CODE && q.sh[3:1] == dev_sel) begin
            d.st     = S_AACK;  // [RULE9] [RULE14]
            d.sda_oe = 1'b1;  // [RULE4]
            d.rd     = q.sh[0];  // [RULE8]
          end else
            d.st = S_IDLE;  // [RULE9]
        end
        S_AACK: begin
          d.bitc = 4'h0;
          if (q.rd) begin
            d.st     = S_RDAT;  // [RULE16] [RULE17]
            d.sh     = mem[q.ptr];
            d.sda_oe = ~mem[q.ptr][7];
            d.bitc   = 4'h1;
          end else begin
            d.st     = S_MADR;
            d.sda_oe = 1'b0;
          end
        end
        S_MADR: if (q.bitc == 4'h8) begin
          d.st      = S_MACK;  // [RULE10]
          d.sda_oe  = 1'b1;
          d.ptr     = q.sh;
          d.pg_base = q.sh;
          d.pg_cnt  = 4'h0;
          d.wr_pend = ~I_WP;  // [RULE20]
        end
        S_MACK, S_WACK: begin
          d.st     = S_WDAT;
          d.sda_oe = 1'b0;
          d.bitc   = 4'h0;
        end
        S_WDAT: if (q.bitc == 4'h8) begin
          d.st     = S_WACK;  // [RULE10] [RULE4]
          d.sda_oe = 1'b1;
          if (q.pg_cnt < 4'(twm_pkg::PAGE_BYTES)) begin
            pg_we    = 1'b1;  // [RULE12]
            d.pg_cnt = q.pg_cnt + 4'h1;
          end
          d.ptr = q.ptr + 8'h01;  // [RULE15]
        end
        S_RDAT: if (q.bitc == 4'h8) begin
          d.st     = S_RACK;
          d.sda_oe = 1'b0;
          d.ptr    = q.ptr + 8'h01;  // [RULE15] [RULE18]
        end else begin
          d.sda_oe = ~q.sh[6];
          d.sh     = {q.sh[6:0], 1'b0};
          d.bitc   = q.bitc + 4'h1;
        end
        S_RACK: ;
        S_IDLE: ;
        default: ;
      endcase
    end
    d.addr_ok = (q.st != S_IDLE);
  end
  always_ff @(posedge I_MCLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      q       <= '0;
      q.scl_s <= 3'h7;
      q.sda_s <= 3'h7;
      q.st    <= S_IDLE;  // [RULE5]
    end else if (I_CE) begin
      q <= d;
    end
  end
  always_ff @(posedge I_MCLK) begin
    if (I_CE && pg_we) pg_buf[q.pg_cnt[2:0]] <= q.sh;
  end
  // nv commit: page bytes land at base+k; sel_reg and mem each have their own writer process
  always_ff @(posedge I_MCLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      sel_reg <= twm_pkg::ADDR_SEL_RST;
    end else if (I_CE && commit) begin
      for (int k = 0; k < twm_pkg::PAGE_BYTES; k++)
        if (4'(k) < q.pg_cnt && (q.pg_base + 8'(k)) == twm_pkg::ADDR_SEL_LOC)
          sel_reg <= pg_buf[k];
    end
  end
  always_ff @(posedge I_MCLK) begin
    if (I_CE && commit) begin
      for (int k = 0; k < twm_pkg::PAGE_BYTES; k++)
        if (4'(k) < q.pg_cnt) mem[q.pg_base + 8'(k)] <= pg_buf[k];  // [RULE13]
    end
  end
  assign bus.sda_s_o  = 1'b0;
  assign bus.sda_s_oe = q.sda_oe;
  assign O_STANDBY    = (q.st == S_IDLE) && (q.nv_cnt == 32'h0000_0000);
  assign O_NV_BUSY    = (q.nv_cnt != 32'h0000_0000);
endmodule

/* hw/twm_pkg.sv */
// shared constants for the two-wire memory slave port and its master
package twm_pkg;
  localparam logic [3:0] DEV_CODE       = 4'ha;
  localparam int         PAGE_BYTES     = 8;
  localparam int         MCLK_HZ        = 25_000_000;
  localparam int         NV_WRITE_US    = 5;
  localparam int         NV_WRITE_CYC   = (NV_WRITE_US * (MCLK_HZ / 1_000_000));
  localparam logic [7:0] MEM_LAST       = 8'hff;
  localparam logic [7:0] ADDR_SEL_LOC   = 8'he7;
  localparam logic [7:0] ADDR_SEL_RST   = 8'h01;
  localparam int         ENB_BIT        = 0;
  localparam int         SEL_LSB        = 1;
  localparam int         SCL_HALF_CYC   = 4;
endpackage

/* hw/twm_bus_if.sv */
// open-drain two-wire bus joining master and slave ends
`timescale 1ns/100ps
interface twm_bus_if;
  logic scl_o;
  logic scl_oe;
  logic sda_m_o;
  logic sda_m_oe;
  logic sda_s_o;
  logic sda_s_oe;
  wire  scl = ~(scl_oe & ~scl_o);
  wire  sda = ~((sda_m_oe & ~sda_m_o) | (sda_s_oe & ~sda_s_o));
  modport slave  (input scl, input sda, output sda_s_o, output sda_s_oe);
  modport master (input scl, input sda, output scl_o, output scl_oe,
                  output sda_m_o, output sda_m_oe);
endinterface

/* hw/twm_master.sv */
// two-wire master end: one byte-level command at a time
`timescale 1ns/100ps
module twm_master #(
  parameter int HALF = twm_pkg::SCL_HALF_CYC
) (
  input  wire logic       I_MCLK,
  input  wire logic       I_RST_B,
  input  wire logic       I_CE,
  input  wire logic       I_CMD_VALID,
  input  wire logic [2:0] I_CMD,
  input  wire logic [7:0] I_WDATA,
  input  wire logic       I_ACK_OUT,
  output logic            O_CMD_READY,
  output logic            O_RSP_VALID,
  input  wire logic       I_RSP_READY,
  output logic [7:0]      O_RDATA,
  output logic            O_NACK,
  twm_bus_if.master       bus
);
  // commands: 0 start, 1 stop, 2 write byte, 3 read byte, 4 recover
  typedef enum {M_IDLE, M_START, M_STOP, M_BIT, M_RECOV} twm_mst_type;
  typedef struct packed {
    twm_mst_type st;
    logic [7:0]  cnt;
    logic [1:0]  ph;
    logic [3:0]  bitc;
    logic [8:0]  sh;
    logic        rdop;
    logic        scl_o;
    logic        sda_o;
    logic [1:0]  bv;
    logic [8:0]  b0;
    logic [8:0]  b1;
    logic [2:0]  sda_s;
  } twm_m_type;
  twm_m_type q, d;
  logic tick, sda_in;
  assign tick   = (q.cnt == 8'(HALF - 1));
  assign sda_in = q.sda_s[2];
  always_comb begin
    d       = q;
    d.sda_s = {q.sda_s[1:0], bus.sda};
    d.cnt   = tick ? 8'h00 : q.cnt + 8'h01;
    if (I_RSP_READY && q.bv != 2'h0) begin
      d.b0 = q.b1;
      d.bv = q.bv - 2'h1;
    end
    if (q.st == M_IDLE) begin
      d.cnt = 8'h00;
      d.ph  = 2'h0;
      if (I_CMD_VALID && q.bv != 2'h2) begin
        d.bitc = 4'h0;
        d.rdop = (I_CMD == 3'h3);
        d.sh   = (I_CMD == 3'h3) ? {8'hff, ~I_ACK_OUT} : {I_WDATA, 1'b1};
        unique case (I_CMD)
          3'h0:    d.st = M_START;
          3'h1:    d.st = M_STOP;
          3'h4:    d.st = M_RECOV;  // [RULE6]
          default: d.st = M_BIT;
        endcase
      end
    end else if (tick) begin
      d.ph = q.ph + 2'h1;
      unique case (q.st)
        M_START: begin  // [RULE1]
          if (q.ph == 2'h0) begin d.sda_o = 1'b1; d.scl_o = 1'b1; end
          else if (q.ph == 2'h1) d.sda_o = 1'b0;
          else begin d.scl_o = 1'b0; d.st = M_IDLE; end
        end
        M_STOP: begin  // [RULE2]
          if (q.ph == 2'h0) begin d.sda_o = 1'b0; d.scl_o = 1'b0; end
          else if (q.ph == 2'h1) d.scl_o = 1'b1;
          else begin d.sda_o = 1'b1; d.st = M_IDLE; end
        end
        M_RECOV: begin
          d.sda_o = 1'b1;
          d.scl_o = ~q.scl_o;
          if (q.scl_o) d.bitc = q.bitc + 4'h1;
          if ((q.scl_o && sda_in) || q.bitc == 4'h9) d.st = M_IDLE;
        end
        M_BIT: begin  // [RULE3]
          if (!q.scl_o) begin
            if (q.ph[0] == 1'b0) d.sda_o = q.sh[8];
            else d.scl_o = 1'b1;
          end else begin
            d.scl_o = 1'b0;
            d.ph    = 2'h0;
            d.sh    = {q.sh[7:0], sda_in};
            d.bitc  = q.bitc + 4'h1;
            if (q.bitc == 4'h8) begin
              d.st = M_IDLE;
              d.bv = d.bv + 2'h1;
              if (d.bv == 2'h1) d.b0 = {q.sh[7:0], sda_in};
              else d.b1 = {q.sh[7:0], sda_in};
              d.sda_o = 1'b1;
            end
          end
        end
        default: d.st = M_IDLE;
      endcase
    end
  end
  always_ff @(posedge I_MCLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      q       <= '0;
      q.st    <= M_IDLE;
      q.scl_o <= 1'b1;
      q.sda_o <= 1'b1;
      q.sda_s <= 3'h7;
    end else if (I_CE) begin
      q <= d;
    end
  end
  assign O_CMD_READY  = (q.st == M_IDLE) && (q.bv != 2'h2);
  assign O_RSP_VALID  = (q.bv != 2'h0);
  assign O_RDATA      = q.b0[8:1];
  assign O_NACK       = q.b0[0];
  assign bus.scl_o    = 1'b0;
  assign bus.scl_oe   = ~q.scl_o;
  assign bus.sda_m_o  = 1'b0;
  assign bus.sda_m_oe = ~q.sda_o;
endmodule

/* tb/twm_bus_monitor.sv */
// assertions on the two-wire bus shared by master and slave ends
`timescale 1ns/100ps
module twm_bus_monitor (
  input wire logic I_MCLK,
  input wire logic I_RST_B,
  input wire logic scl_o,
  input wire logic scl_oe,
  input wire logic sda_m_o,
  input wire logic sda_m_oe,
  input wire logic sda_s_o,
  input wire logic sda_s_oe,
  input wire logic scl,
  input wire logic sda
);
  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (!I_RST_B);

  AST_SLV_STEADY: assert property (scl && $past(scl) |-> $stable(sda_s_oe))
    else $error("slave moved sda while scl high");
  AST_SLV_DRIVE_ZERO: assert property (sda_s_oe |-> !sda_s_o)
    else $error("slave drove sda other than low");
  AST_MST_DRIVE_ZERO: assert property ((scl_oe |-> !scl_o) and (sda_m_oe |-> !sda_m_o))
    else $error("master drove a line other than low");
  AST_SLV_TAKE_LOW: assert property ($rose(sda_s_oe) |-> !scl)
    else $error("slave took sda with scl high");
  AST_SLV_FREE_LOW: assert property ($fell(sda_s_oe) |-> !scl)
    else $error("slave freed sda with scl high");
  AST_SLV_BOUND: assert property ($rose(sda_s_oe) |-> ##[1:200] !sda_s_oe)
    else $error("slave held sda too long");
  AST_START_QUIET: assert property ($fell(sda) && scl |=> !sda_s_oe [*8])
    else $error("slave drove sda right after start");
  AST_STOP_QUIET: assert property ($rose(sda) && scl && $past(scl) |=> !sda_s_oe [*8])
    else $error("slave drove sda right after stop");
  AST_MST_START: assert property ($rose(sda_m_oe) && scl && $past(scl) |-> ##[1:16] scl_oe)
    else $error("no clock low after start");
  AST_MST_STOP: assert property ($fell(sda_m_oe) && scl && $past(scl) && !sda_s_oe
                                 |=> !scl_oe [*4])
    else $error("clock pulled right after stop");

  cover property (sda_s_oe && scl);
  cover property ($fell(sda) && scl);
  cover property ($rose(sda) && scl);
endmodule

/* tb/tb_two_wire_memory_slave_port.sv */
// bench: master and slave ends joined by one bus
`timescale 1ns/100ps
module tb_two_wire_memory_slave_port;
  localparam logic [7:0] AW = {twm_pkg::DEV_CODE, 3'h5, 1'h0};
  localparam logic [7:0] AR = AW | 8'h01;
  localparam logic [7:0] AW3 = {twm_pkg::DEV_CODE, 3'h3, 1'h0};
  logic       mclk, rst_b, ce, wp, cmd_valid, ack_out, rsp_ready;
  logic       cmd_ready, rsp_valid, nack, standby, nv_busy, n;
  logic [2:0] sel, cmd;
  logic [7:0] wdata, rdata, r;
  int         num_errors = 0;
  int         num_checks = 0;
  int         cyc = 0;
  int         k;

  twm_bus_if twm_bus ();
  twm_slave #(.NV_CYC(300)) i_twm_slave (.I_MCLK(mclk), .I_RST_B(rst_b), .I_CE(ce),
    .I_SEL_PINS(sel), .I_WP(wp), .O_STANDBY(standby), .O_NV_BUSY(nv_busy), .bus(twm_bus));
  twm_master i_twm_master (.I_MCLK(mclk), .I_RST_B(rst_b), .I_CE(ce),
    .I_CMD_VALID(cmd_valid), .I_CMD(cmd), .I_WDATA(wdata), .I_ACK_OUT(ack_out),
    .O_CMD_READY(cmd_ready), .O_RSP_VALID(rsp_valid), .I_RSP_READY(rsp_ready),
    .O_RDATA(rdata), .O_NACK(nack), .bus(twm_bus));
  twm_bus_monitor i_twm_bus_monitor (.I_MCLK(mclk), .I_RST_B(rst_b),
    .scl_o(twm_bus.scl_o), .scl_oe(twm_bus.scl_oe), .sda_m_o(twm_bus.sda_m_o),
    .sda_m_oe(twm_bus.sda_m_oe), .sda_s_o(twm_bus.sda_s_o), .sda_s_oe(twm_bus.sda_s_oe),
    .scl(twm_bus.scl), .sda(twm_bus.sda));

  task wrap_up();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task chk(input logic ok, input string m);
    num_checks++;
    if (!ok) begin
      num_errors++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask
  task send(input logic [2:0] c, input logic [7:0] d, input logic a);
    @(posedge mclk);
    cmd_valid <= 1'h1;
    cmd       <= c;
    wdata     <= d;
    ack_out   <= a;
    @(negedge mclk);
    while (cmd_ready !== 1'h1) @(negedge mclk);
    @(posedge mclk);
    cmd_valid <= 1'h0;
  endtask
  task pop();
    @(posedge mclk);
    rsp_ready <= 1'h1;
    @(negedge mclk);
    while (rsp_valid !== 1'h1) @(negedge mclk);
    r = rdata;
    n = nack;
    @(posedge mclk);
    rsp_ready <= 1'h0;
  endtask
  task go(input logic [2:0] c);
    send(c, 8'h00, 1'h0);
  endtask
  task wb(input logic [7:0] d, input logic e);
    send(3'h2, d, 1'h0);
    pop();
    chk(n === e, "byte ack");
  endtask
  task rb(input logic a, input logic [7:0] e);
    send(3'h3, 8'h00, a);
    pop();
    chk(r === e, "read data");
  endtask
  task poll(input logic [7:0] a);
    k = 0;
    n = 1'h1;
    while (n !== 1'h0 && k < 50) begin
      go(3'h0);
      send(3'h2, a, 1'h0);
      pop();
      go(3'h1);
      k++;
    end
    chk(n === 1'h0, "poll ack");
  endtask
  task rr(input logic [7:0] a, input logic [7:0] e);
    go(3'h0); wb(AW, 1'h0); wb(a, 1'h0);
    go(3'h0); wb(AR, 1'h0); rb(1'h0, e); go(3'h1);
  endtask

  initial begin
    mclk = 1'h0;
    forever #20 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 40000) begin
      num_errors++;
      wrap_up();
    end
  end

  initial begin
    rst_b = 1'h0; ce = 1'h1; wp = 1'h0; sel = 3'h5; cmd_valid = 1'h0;
    cmd = 3'h0; wdata = 8'h00; ack_out = 1'h0; rsp_ready = 1'h0;
    repeat (2) @(posedge mclk);
    rst_b <= 1'h1;
    @(negedge mclk);
    chk(standby === 1'h1, "standby after reset");
    go(3'h4);
    go(3'h0); wb(AW ^ 8'h0e, 1'h1); go(3'h1);
    go(3'h0); wb(AW ^ 8'h80, 1'h1); go(3'h1);
    $display("test addressing done");
    go(3'h0); wb(AW, 1'h0); wb(8'h00, 1'h0); wb(8'h5a, 1'h0); go(3'h1);
    @(negedge mclk);
    while (cmd_ready !== 1'h1) @(negedge mclk);
    repeat (4) @(negedge mclk);
    chk(nv_busy === 1'h1 && standby === 1'h0, "nv write after stop");
    poll(AW);
    go(3'h0); wb(AW, 1'h0); wb(8'hf8, 1'h0);
    for (int i = 0; i < 8; i++) begin
      send(3'h2, 8'h10 + 8'(i), 1'h0);
      if (i[0]) begin
        pop(); chk(n === 1'h0, "page ack");
        pop(); chk(n === 1'h0, "page ack");
      end
    end
    go(3'h1);
    poll(AW);
    chk(k > 1, "no ack while busy");
    $display("test writes done");
    go(3'h0); wb(AW, 1'h0); wb(8'hfe, 1'h0); go(3'h0); wb(AR, 1'h0);
    rb(1'h1, 8'h16); rb(1'h0, 8'h17); go(3'h1);
    go(3'h0); wb(AR, 1'h0); rb(1'h0, 8'h5a); go(3'h1);
    $display("test reads done");
    go(3'h0); wb(AW, 1'h0); wb(8'hff, 1'h0); wb(8'h33, 1'h0);
    go(3'h0); wb(AR, 1'h0); rb(1'h0, 8'h5a); go(3'h1);
    rr(8'hff, 8'h17);
    wp <= 1'h1;
    go(3'h0); wb(AW, 1'h0); wb(8'h00, 1'h0); wb(8'ha5, 1'h0); go(3'h1);
    poll(AW);
    wp <= 1'h0;
    rr(8'h00, 8'h5a);
    go(3'h0); wb(AW, 1'h0); wb(twm_pkg::ADDR_SEL_LOC, 1'h0); wb(8'h06, 1'h0); go(3'h1);
    sel <= 3'h0;
    poll(AW3);
    go(3'h0); wb(AW3, 1'h0); wb(twm_pkg::ADDR_SEL_LOC, 1'h0); wb(8'h01, 1'h0); go(3'h1);
    sel <= 3'h5;
    poll(AW);
    for (int j = 0; j < 200 && standby !== 1'h1; j++) @(negedge mclk);
    chk(standby === 1'h1, "standby after stop");
    $display("test protect done");
    wrap_up();
  end
endmodule
